// File: common/nal_defs.svh
// Constants for the nibble ALU: register offsets, status word bit
// positions, reset values and the decimal correction tables.
// Assumes inclusion by bare name from any file that needs them.
`ifndef NAL_DEFS_SVH
`define NAL_DEFS_SVH

// ***************************************************************
// Register offsets (byte addresses, one aligned word each)
// ***************************************************************
`define NAL_OFS_PSW    4'h0
`define NAL_OFS_MODE   4'h4
`define NAL_OFS_STATUS 4'h8

// ***************************************************************
// Program status word bit positions
// ***************************************************************
`define NAL_PSW_INDEX_MOD_ENABLE 0
`define NAL_PSW_ZF               1
`define NAL_PSW_CARRY_BIT        2
`define NAL_PSW_SI               3

// ***************************************************************
// Reset values
// ***************************************************************
`define NAL_PSW_RST  4'h0
`define NAL_MODE_RST 1'b0

// ***************************************************************
// Decimal correction: highest valid digit, tables by binary value
// ***************************************************************
`define NAL_DEC_MAX 5'h09
`define NAL_DEC_ADD_TBL 128'hDCBADCFEDCFE98765432109876543210
`define NAL_DEC_SUB_TBL 128'h9876543210FEDCFEDCFEDC9876543210

`endif

// File: common/nal_pkg.sv
// Types shared by the nibble ALU modules: operations and states.
// Assumes nothing of its surroundings.
package nal_pkg;

  // Operations requested by the instruction sequencer
  typedef enum logic [3:0] {
    NAL_OP_ADD,
    NAL_OP_ADD_WITH_CARRY_IN,
    NAL_OP_SUB,
    NAL_OP_SUBTRACT_WITH_BORROW_IN,
    NAL_OP_OR,
    NAL_OP_AND,
    NAL_OP_XOR,
    NAL_OP_SKT,
    NAL_OP_SKF,
    NAL_OP_SKE,
    NAL_OP_SKNE,
    NAL_OP_SKGE,
    NAL_OP_SKLT,
    NAL_OP_ROTATE_RIGHT_THROUGH_CARRY
  } nal_op_type;

  // Sequencing of one operation
  typedef enum logic {
    NAL_ST_IDLE,
    NAL_ST_EXEC
  } nal_state_type;

endpackage

// File: hdl/nal_dec_correct.sv
// Decimal correction stage of the nibble ALU.
// Assumes a 5-bit binary sum or difference with carry/borrow on top.
`timescale 1ns/1ps
`default_nettype none
`include "nal_defs.svh"

module nal_dec_correct (
  input  wire logic [4:0] bin_i,
  input  wire logic       is_sub_i,
  output logic      [3:0] digit_o,
  output logic            carry_o
);

  // ***************************************************************
  // Table lookup
  // ***************************************************************
  localparam logic [127:0] ADD_TBL = `NAL_DEC_ADD_TBL;
  localparam logic [127:0] SUB_TBL = `NAL_DEC_SUB_TBL;

  logic [6:0] bit_idx;

  // Four bits per entry; out-of-range values land on 1010B or above
  assign bit_idx = {bin_i, 2'b00};
  assign digit_o = is_sub_i ? SUB_TBL[bit_idx +: 4]
                            : ADD_TBL[bit_idx +: 4];
  // Anything above nine, or any borrow, is a decimal carry
  assign carry_o = (bin_i > `NAL_DEC_MAX);

endmodule
`default_nettype wire

// File: hdl/nal_alu.sv
// Nibble ALU with status word flag logic and a Wishbone register file.
// Assumes the sequencer presents operands with a one-cycle request and
// writes the result to register file or data memory on wr_en_o.
//
// Contract
// - Latch operands into temporaries A and B first
// - Compute every result from temporaries A, B
// - Arithmetic, logic, rotate write back to destination
// - Judgements write nothing, output skip decision
// - Bit tests clear the store inhibit flag
// - Index enable modifies operand address by index
// - Add, add carry, sub, sub borrow supported
// - Binary mode stores result, carry on overflow
// - Binary zero flag follows zero result
// - Store inhibit suppresses write, carry still updates
// - Inhibit: zero keeps flag, nonzero clears it
// - Decimal stores result, carry above nine
// - Decimal result via binary then correction stage
// - Out of range decimal gives carry, big digit
// - Inhibit plus decimal: decimal flags, no write
// - Status word destination overwrites flags; for arithmetic only when not inhibited
// - OR, AND, XOR in both operand forms
// - Logic ignores modes; writes and keeps flags unless the status word is the destination
`timescale 1ns/1ps
`default_nettype none
`include "nal_defs.svh"

module nal_alu #(
  parameter int ADDR_W = 7
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // Wishbone classic slave
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [3:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  // Sequencer request
  input  wire logic              op_valid_i,
  input  wire nal_pkg::nal_op_type op_code_i,
  input  wire logic [3:0]        op_a_i,
  input  wire logic [3:0]        op_b_i,
  input  wire logic [ADDR_W-1:0] op_addr_i,
  input  wire logic [ADDR_W-1:0] index_reg_i,
  input  wire logic              dest_psw_i,
  // Answer
  output logic                   busy_o,
  output logic                   done_o,
  output logic      [3:0]        result_o,
  output logic                   wr_en_o,
  output logic      [ADDR_W-1:0] wr_addr_o,
  output logic                   skip_o,
  output logic      [3:0]        psw_o
);

  // ***************************************************************
  // Decoding helpers
  // ***************************************************************
  function automatic logic is_arith(input nal_pkg::nal_op_type op);
    return op inside {nal_pkg::NAL_OP_ADD,
                      nal_pkg::NAL_OP_ADD_WITH_CARRY_IN,
                      nal_pkg::NAL_OP_SUB,
                      nal_pkg::NAL_OP_SUBTRACT_WITH_BORROW_IN};
  endfunction

  function automatic logic is_logic(input nal_pkg::nal_op_type op);
    return op inside {nal_pkg::NAL_OP_OR, nal_pkg::NAL_OP_AND,
                      nal_pkg::NAL_OP_XOR};
  endfunction

  function automatic logic is_bit_test(input nal_pkg::nal_op_type op);
    return op inside {nal_pkg::NAL_OP_SKT, nal_pkg::NAL_OP_SKF};
  endfunction

  function automatic logic is_judge(input nal_pkg::nal_op_type op);
    return op inside {nal_pkg::NAL_OP_SKT, nal_pkg::NAL_OP_SKF,
                      nal_pkg::NAL_OP_SKE, nal_pkg::NAL_OP_SKNE,
                      nal_pkg::NAL_OP_SKGE, nal_pkg::NAL_OP_SKLT};
  endfunction

  // ***************************************************************
  // State and temporaries
  // ***************************************************************
  nal_pkg::nal_state_type state;
  nal_pkg::nal_op_type    op_reg;
  logic [3:0]             a_reg;
  logic [3:0]             b_reg;
  logic [ADDR_W-1:0]      addr_reg;
  logic                   dest_psw_reg;
  logic [3:0]             psw;
  logic                   decimal_mode;
  logic                   bus_req;
  logic                   take_op;
  logic                   exec;
  logic [ADDR_W-1:0]      next_addr;

  assign take_op = op_valid_i && (state == nal_pkg::NAL_ST_IDLE);
  assign exec    = (state == nal_pkg::NAL_ST_EXEC);
  assign busy_o  = exec;
  assign psw_o   = psw;

  // Operand address, modified by the index register when enabled
  assign next_addr = psw[`NAL_PSW_INDEX_MOD_ENABLE] ?
                     ADDR_W'(op_addr_i + index_reg_i) : op_addr_i;

  // Two-step sequence: latch, then execute; requests while busy dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= nal_pkg::NAL_ST_IDLE;
    end else begin
      unique case (state)
        nal_pkg::NAL_ST_IDLE: begin
          if (op_valid_i) begin
            state <= nal_pkg::NAL_ST_EXEC;
          end
        end
        nal_pkg::NAL_ST_EXEC: begin
          state <= nal_pkg::NAL_ST_IDLE;
        end
      endcase
    end
  end

  // Operand capture into temporaries A and B
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      op_reg       <= nal_pkg::NAL_OP_ADD;
      a_reg        <= 4'h0;
      b_reg        <= 4'h0;
      addr_reg     <= '0;
      dest_psw_reg <= 1'b0;
    end else if (take_op) begin
      op_reg       <= op_code_i;
      a_reg        <= op_a_i;
      b_reg        <= op_b_i;
      addr_reg     <= next_addr;
      dest_psw_reg <= dest_psw_i;
    end
  end

  // ***************************************************************
  // Datapath
  // ***************************************************************
  logic       store_inhibit;
  logic       carry_in;
  logic       op_sub;
  logic [4:0] bin5;
  logic [3:0] dec_digit;
  logic       dec_carry;
  logic [3:0] arith_nib;
  logic       arith_carry;
  logic [3:0] logic_nib;
  logic       judge_skip;
  logic       is_rotate;

  assign store_inhibit = psw[`NAL_PSW_SI];
  assign op_sub = (op_reg == nal_pkg::NAL_OP_SUB) ||
                  (op_reg == nal_pkg::NAL_OP_SUBTRACT_WITH_BORROW_IN);
  assign is_rotate = (op_reg == nal_pkg::NAL_OP_ROTATE_RIGHT_THROUGH_CARRY);
  // Carry flag as extra addend or subtrahend
  assign carry_in = ((op_reg == nal_pkg::NAL_OP_ADD_WITH_CARRY_IN) ||
                     (op_reg == nal_pkg::NAL_OP_SUBTRACT_WITH_BORROW_IN)) &&
                    psw[`NAL_PSW_CARRY_BIT];

  // Binary sum or difference; bit 4 is carry or borrow
  assign bin5 = op_sub ?
                5'({1'b0, a_reg} - {1'b0, b_reg} - {4'h0, carry_in}) :
                5'({1'b0, a_reg} + {1'b0, b_reg} + {4'h0, carry_in});

  // Correction follows the binary step
  nal_dec_correct u_dec (
    .bin_i    (bin5),
    .is_sub_i (op_sub),
    .digit_o  (dec_digit),
    .carry_o  (dec_carry)
  );

  // Mode select; decimal limit nine, binary limit the fifth bit
  assign arith_nib = decimal_mode ? dec_digit : bin5[3:0];
  assign arith_carry = decimal_mode ? dec_carry : bin5[4];

  // Bitwise operations ignore every mode flag
  always_comb begin
    unique case (op_reg)
      nal_pkg::NAL_OP_OR:  logic_nib = a_reg | b_reg;
      nal_pkg::NAL_OP_AND: logic_nib = a_reg & b_reg;
      default:             logic_nib = a_reg ^ b_reg;
    endcase
  end

  // Skip decision for bit tests and comparisons
  always_comb begin
    unique case (op_reg)
      nal_pkg::NAL_OP_SKT:  judge_skip = ((a_reg & b_reg) == b_reg);
      nal_pkg::NAL_OP_SKF:  judge_skip = ((a_reg & b_reg) == 4'h0);
      nal_pkg::NAL_OP_SKE:  judge_skip = (a_reg == b_reg);
      nal_pkg::NAL_OP_SKNE: judge_skip = (a_reg != b_reg);
      nal_pkg::NAL_OP_SKGE: judge_skip = (a_reg >= b_reg);
      nal_pkg::NAL_OP_SKLT: judge_skip = (a_reg < b_reg);
      default:              judge_skip = 1'b0;
    endcase
  end

  // ***************************************************************
  // Answer to the sequencer
  // ***************************************************************
  // Registered outputs, valid in the cycle that done_o is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      done_o    <= 1'b0;
      wr_en_o   <= 1'b0;
      result_o  <= 4'h0;
      wr_addr_o <= '0;
      skip_o    <= 1'b0;
    end else begin
      done_o  <= exec;
      wr_en_o <= 1'b0;
      skip_o  <= 1'b0;
      if (exec) begin
        wr_addr_o <= addr_reg;
        if (is_arith(op_reg)) begin
          result_o <= arith_nib;
          // Inhibit or status word destination: no external write
          wr_en_o  <= !store_inhibit && !dest_psw_reg;
        end else if (is_logic(op_reg)) begin
          result_o <= logic_nib;
          wr_en_o  <= !dest_psw_reg;
        end else if (is_rotate) begin
          result_o <= {psw[`NAL_PSW_CARRY_BIT], a_reg[3:1]};
          wr_en_o  <= !dest_psw_reg;
        end else begin
          skip_o   <= judge_skip;
        end
      end
    end
  end

  // ***************************************************************
  // Register file over Wishbone
  // ***************************************************************
  logic bus_wr;

  assign bus_req = wb_cyc_i && wb_stb_i;
  // Write lands on the edge where the master sees ack
  assign bus_wr  = bus_req && wb_we_i && wb_ack_o && wb_sel_i[0];

  // One wait state, then ack for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  // Read mux; unmapped addresses read zero and are still acked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_ack_o) begin
      unique case (wb_adr_i)
        `NAL_OFS_PSW:    wb_dat_o <= {28'h0000000, psw};
        `NAL_OFS_MODE:   wb_dat_o <= {31'h0, decimal_mode};
        `NAL_OFS_STATUS: wb_dat_o <= {26'h0, busy_o, skip_o,
                                      result_o};
        default:         wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Decimal mode select, software only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      decimal_mode <= `NAL_MODE_RST;
    end else if (bus_wr && (wb_adr_i == `NAL_OFS_MODE)) begin
      decimal_mode <= wb_dat_i[0];
    end
  end

  // ***************************************************************
  // Program status word
  // ***************************************************************
  logic       next_zero;
  logic       status_dest;

  // Under inhibit a zero keeps the old flag, so chained compares
  // accumulate equality across digits
  assign next_zero = store_inhibit ?
                     ((arith_nib == 4'h0) && psw[`NAL_PSW_ZF]) :
                     (arith_nib == 4'h0);
  assign status_dest = dest_psw_reg && !store_inhibit;

  // Hardware update wins over a bus write in the same cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      psw <= `NAL_PSW_RST;
    end else if (exec && is_arith(op_reg)) begin
      if (status_dest) begin
        psw <= arith_nib;
      end else begin
        psw[`NAL_PSW_CARRY_BIT] <= arith_carry;
        psw[`NAL_PSW_ZF]        <= next_zero;
      end
    end else if (exec && is_bit_test(op_reg)) begin
      psw[`NAL_PSW_SI] <= 1'b0;
    end else if (exec && dest_psw_reg && !is_judge(op_reg)) begin
      // Logic and rotate into the status word store their value
      psw <= is_logic(op_reg) ? logic_nib :
             {psw[`NAL_PSW_CARRY_BIT], a_reg[3:1]};
    end else if (exec && is_rotate) begin
      psw[`NAL_PSW_CARRY_BIT] <= a_reg[0];
    end else if (bus_wr && (wb_adr_i == `NAL_OFS_PSW)) begin
      psw <= wb_dat_i[3:0];
    end
  end

  // ***************************************************************
  // Assertions
  // ***************************************************************
  a_latch_operands: assert property (@(posedge clk_i) disable iff (rst_i)
    take_op |=> (a_reg == $past(op_a_i)) && (b_reg == $past(op_b_i))
  ) else $error("Operands not latched");

  a_index_address: assert property (@(posedge clk_i) disable iff (rst_i)
    take_op && psw[`NAL_PSW_INDEX_MOD_ENABLE] |=>
      addr_reg == ADDR_W'($past(op_addr_i) + $past(index_reg_i))
  ) else $error("Index not applied");

  a_logic_result: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && op_reg == nal_pkg::NAL_OP_AND |=>
      done_o && result_o == ($past(a_reg) & $past(b_reg))
  ) else $error("Wrong AND result");

  a_logic_writes: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_logic(op_reg) && !dest_psw_reg |=>
      wr_en_o && $stable(psw[`NAL_PSW_CARRY_BIT]) &&
      $stable(psw[`NAL_PSW_ZF])
  ) else $error("Logic op wrote flags or skipped store");

  a_judge_no_write: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_judge(op_reg) |=> !wr_en_o && skip_o == $past(judge_skip)
  ) else $error("Judgement wrote a value");

  a_bit_test_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_bit_test(op_reg) |=> !psw[`NAL_PSW_SI]
  ) else $error("Store inhibit not cleared");

  a_inhibit_store: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_arith(op_reg) && store_inhibit |=>
      !wr_en_o && psw[`NAL_PSW_CARRY_BIT] == $past(arith_carry)
  ) else $error("Inhibited result stored");

  a_zero_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_arith(op_reg) && store_inhibit && arith_nib == 4'h0 |=>
      $stable(psw[`NAL_PSW_ZF])
  ) else $error("Zero flag changed on zero");

  a_binary_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_arith(op_reg) && !decimal_mode && !status_dest |=>
      psw[`NAL_PSW_CARRY_BIT] == $past(bin5[4]) &&
      psw[`NAL_PSW_ZF] == ($past(bin5[3:0]) == 4'h0 &&
        (!$past(store_inhibit) || $past(psw[`NAL_PSW_ZF])))
  ) else $error("Binary flags wrong");

  a_decimal_carry: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_arith(op_reg) && decimal_mode && !status_dest |=>
      psw[`NAL_PSW_CARRY_BIT] == ($past(bin5) > `NAL_DEC_MAX)
  ) else $error("Decimal carry wrong");

  a_status_dest: assert property (@(posedge clk_i) disable iff (rst_i)
    exec && is_arith(op_reg) && status_dest |=>
      psw == $past(arith_nib) && !wr_en_o
  ) else $error("Status word not overwritten");

  a_done_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    take_op |=> busy_o ##1 (done_o && !busy_o) ##1 !done_o
  ) else $error("Done not one cycle after execute");

endmodule
`default_nettype wire

// File: verification/nal_seq_model.sv
// Sequencer partner model: issues one ALU request, keeps a data memory.
// Assumes the ALU answers with done_i and a write strobe in one cycle.
`timescale 1ns/1ps
`default_nettype none
module nal_seq_model (
  input  wire logic                clk_i,
  input  wire logic                done_i,
  input  wire logic                busy_i,
  input  wire logic [3:0]          result_i,
  input  wire logic                wr_en_i,
  input  wire logic [6:0]          wr_addr_i,
  input  wire logic                skip_i,
  output logic                     op_valid_o,
  output var nal_pkg::nal_op_type  op_code_o,
  output logic      [3:0]          op_a_o,
  output logic      [3:0]          op_b_o,
  output logic      [6:0]          op_addr_o,
  output logic      [6:0]          index_reg_o,
  output logic                     dest_psw_o
);
  logic [3:0] mem [0:127];
  logic [3:0] last_res;
  logic [6:0] last_addr;
  logic       last_wr;
  logic       last_skip;
  logic       last_busy;
  int         last_lat;

  // Quiet request fields from time zero
  initial begin
    op_valid_o = 1'b0;
    op_code_o = nal_pkg::NAL_OP_ADD;
    op_a_o = 4'h0;
    op_b_o = 4'h0;
    op_addr_o = 7'h00;
    index_reg_o = 7'h00;
    dest_psw_o = 1'b0;
  end

  // One request; operands scrambled after the taking edge so a late
  // latch of A or B shows up as a wrong result
  task automatic run(input nal_pkg::nal_op_type c, input logic [3:0] a,
                     input logic [3:0] b, input logic [6:0] ad,
                     input logic [6:0] ix, input logic dp);
    int n;
    @(posedge clk_i);
    op_valid_o <= 1'b1;
    op_code_o <= c;
    op_a_o <= a;
    op_b_o <= b;
    op_addr_o <= ad;
    index_reg_o <= ix;
    dest_psw_o <= dp;
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    op_a_o <= ~a;
    op_b_o <= ~b;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      // Execute cycle is the one right after the taking edge
      if (n == 1) last_busy = busy_i;
    end while (done_i !== 1'b1 && n < 8);
    last_lat = n;
    last_res = result_i;
    last_wr = wr_en_i;
    last_skip = skip_i;
    last_addr = wr_addr_i;
    // Write-back lands only on the strobe
    if (wr_en_i === 1'b1) mem[wr_addr_i] = result_i;
  endtask
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Testbench for the nibble ALU: bus tasks, scenarios and verdict.
// Assumes the package, the ALU and the sequencer model compile first.
`timescale 1ns/1ps
`default_nettype none
`include "nal_defs.svh"
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i, result_o, psw_o, op_a_i, op_b_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic op_valid_i, dest_psw_i, busy_o, done_o, wr_en_o, skip_o;
  logic [6:0] op_addr_i, index_reg_i, wr_addr_o;
  nal_pkg::nal_op_type op_code_i;
  int n_fail = 0;
  int checked = 0;
  int cycles = 0;

  always #4 clk_i = ~clk_i;

  nal_alu #(.ADDR_W(7)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .op_valid_i(op_valid_i),
    .op_code_i(op_code_i), .op_a_i(op_a_i), .op_b_i(op_b_i),
    .op_addr_i(op_addr_i), .index_reg_i(index_reg_i),
    .dest_psw_i(dest_psw_i), .busy_o(busy_o), .done_o(done_o),
    .result_o(result_o), .wr_en_o(wr_en_o), .wr_addr_o(wr_addr_o),
    .skip_o(skip_o), .psw_o(psw_o));

  nal_seq_model SEQ (.clk_i(clk_i), .done_i(done_o), .busy_i(busy_o),
    .result_i(result_o),
    .wr_en_i(wr_en_o), .wr_addr_i(wr_addr_o), .skip_i(skip_o),
    .op_valid_o(op_valid_i), .op_code_o(op_code_i), .op_a_o(op_a_i),
    .op_b_o(op_b_i), .op_addr_o(op_addr_i), .index_reg_o(index_reg_i),
    .dest_psw_o(dest_psw_i));

  // ************************************************
  // Compare and bus tasks
  // ************************************************
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: word %h, want %h", $time, g, e);
    end
  endtask

  task automatic chk_nib(input logic [3:0] g, input logic [3:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: nibble %h, want %h", $time, g, e);
    end
  endtask

  // Classic cycle: held until ack is sampled, then released
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d);
    int n;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Runs one operation; ws[1] write expected, ws[0] skip expected
  task automatic op(input nal_pkg::nal_op_type c, input logic [3:0] a,
      input logic [3:0] b, input logic [3:0] r, input logic [3:0] p,
      input logic [1:0] ws, input logic dp = 1'b0,
      input logic [6:0] ad = 7'h2A, input logic [6:0] ix = 7'h15);
    logic [6:0] e_ad;
    // Ops with a memory destination never touch index enable
    e_ad = p[`NAL_PSW_INDEX_MOD_ENABLE] ? ad + ix : ad;
    SEQ.run(c, a, b, ad, ix, dp);
    if (c < nal_pkg::NAL_OP_SKT ||
        c == nal_pkg::NAL_OP_ROTATE_RIGHT_THROUGH_CARRY)
      chk_nib(SEQ.last_res, r);
    chk_nib(psw_o, p);
    chk_nib({3'h0, SEQ.last_busy}, 4'h1);
    chk_val(32'(SEQ.last_lat), 32'h0000_0002);
    chk_nib({3'h0, SEQ.last_wr}, {3'h0, ws[1]});
    chk_nib({3'h0, SEQ.last_skip}, {3'h0, ws[0]});
    if (ws[1]) begin
      chk_nib(SEQ.mem[e_ad], r);
      chk_val(32'(SEQ.last_addr), 32'(e_ad));
    end
  endtask

  // ************************************************
  // Scenarios
  // ************************************************
  task automatic t_binary;
    wb(1'b1, `NAL_OFS_PSW, 32'h0);
    op(nal_pkg::NAL_OP_ADD, 4'h9, 4'h8, 4'h1, 4'h4, 2'h2);
    op(nal_pkg::NAL_OP_ADD_WITH_CARRY_IN,
       4'h3, 4'h4, 4'h8, 4'h0, 2'h2);
    op(nal_pkg::NAL_OP_SUB, 4'h3, 4'h5, 4'hE, 4'h4, 2'h2);
    op(nal_pkg::NAL_OP_SUBTRACT_WITH_BORROW_IN,
       4'h5, 4'h4, 4'h0, 4'h2, 2'h2);
    op(nal_pkg::NAL_OP_ADD, 4'h8, 4'h8, 4'h0, 4'h6, 2'h2);
    op(nal_pkg::NAL_OP_ADD, 4'h0, 4'h2, 4'h2, 4'h2, 2'h0, 1'b1);
  endtask

  task automatic t_inhibit;
    wb(1'b1, `NAL_OFS_PSW, 32'hA);
    op(nal_pkg::NAL_OP_SUB, 4'h5, 4'h5, 4'h0, 4'hA, 2'h0);
    op(nal_pkg::NAL_OP_SUB, 4'h3, 4'h5, 4'hE, 4'hC, 2'h0);
    op(nal_pkg::NAL_OP_ADD, 4'h1, 4'h1, 4'h2, 4'h8, 2'h0, 1'b1);
  endtask

  task automatic t_decimal;
    wb(1'b1, `NAL_OFS_MODE, 32'h1);
    wb(1'b1, `NAL_OFS_PSW, 32'h0);
    op(nal_pkg::NAL_OP_ADD, 4'h9, 4'h8, 4'h7, 4'h4, 2'h2);
    op(nal_pkg::NAL_OP_ADD, 4'h5, 4'h5, 4'h0, 4'h6, 2'h2);
    op(nal_pkg::NAL_OP_SUB, 4'h3, 4'h5, 4'h8, 4'h4, 2'h2);
    op(nal_pkg::NAL_OP_ADD, 4'hF, 4'hF, 4'hC, 4'h4, 2'h2);
    wb(1'b1, `NAL_OFS_PSW, 32'h8);
    op(nal_pkg::NAL_OP_ADD, 4'h4, 4'h5, 4'h9, 4'h8, 2'h0);
  endtask

  // Decimal mode left on: logic must not care
  task automatic t_logic;
    wb(1'b1, `NAL_OFS_PSW, 32'hE);
    op(nal_pkg::NAL_OP_OR, 4'h5, 4'hA, 4'hF, 4'hE, 2'h2);
    op(nal_pkg::NAL_OP_AND, 4'hC, 4'h6, 4'h4, 4'hE, 2'h2);
    op(nal_pkg::NAL_OP_XOR, 4'hF, 4'h5, 4'hA, 4'hE, 2'h2);
    wb(1'b1, `NAL_OFS_MODE, 32'h0);
  endtask

  task automatic t_judge;
    wb(1'b1, `NAL_OFS_PSW, 32'h8);
    op(nal_pkg::NAL_OP_SKT, 4'hB, 4'hB, 4'h0, 4'h0, 2'h1);
    op(nal_pkg::NAL_OP_SKT, 4'hB, 4'hD, 4'h0, 4'h0, 2'h0);
    op(nal_pkg::NAL_OP_SKF, 4'h9, 4'h6, 4'h0, 4'h0, 2'h1);
    wb(1'b1, `NAL_OFS_PSW, 32'h8);
    op(nal_pkg::NAL_OP_SKE, 4'hA, 4'hA, 4'h0, 4'h8, 2'h1);
    op(nal_pkg::NAL_OP_SKNE, 4'hA, 4'h8, 4'h0, 4'h8, 2'h1);
    op(nal_pkg::NAL_OP_SKGE, 4'h5, 4'h5, 4'h0, 4'h8, 2'h1);
    op(nal_pkg::NAL_OP_SKLT, 4'h5, 4'h5, 4'h0, 4'h8, 2'h0);
  endtask

  // Address sums wrap at the top of the space
  task automatic t_index;
    wb(1'b1, `NAL_OFS_PSW, 32'h1);
    op(nal_pkg::NAL_OP_ADD, 4'h1, 4'h1, 4'h2, 4'h1, 2'h2,
       1'b0, 7'h70, 7'h20);
    op(nal_pkg::NAL_OP_OR, 4'h1, 4'h2, 4'h3, 4'h1, 2'h2,
       1'b0, 7'h05, 7'h7F);
  endtask

  task automatic t_rotate;
    wb(1'b1, `NAL_OFS_PSW, 32'h4);
    op(nal_pkg::NAL_OP_ROTATE_RIGHT_THROUGH_CARRY,
       4'h6, 4'h0, 4'hB, 4'h0, 2'h2);
    op(nal_pkg::NAL_OP_ROTATE_RIGHT_THROUGH_CARRY,
       4'h3, 4'h0, 4'h1, 4'h4, 2'h2);
    wb(1'b0, `NAL_OFS_STATUS, 32'h0);
    chk_val(rd, 32'h1);
    wb(1'b1, `NAL_OFS_STATUS, 32'hFF);
    wb(1'b0, `NAL_OFS_STATUS, 32'h0);
    chk_val(rd, 32'h1);
    wb(1'b0, 4'hC, 32'h0);
    chk_val(rd, 32'h0);
    wb(1'b0, `NAL_OFS_PSW, 32'h0);
    chk_val(rd, 32'h4);
  endtask

  // ************************************************
  // Verdict, watchdog and main sequence
  // ************************************************
  task automatic end_of_test;
    $display("mismatches %0d, comparisons %0d", n_fail, checked);
    if (n_fail == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Whole run needs well under a thousand cycles
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_binary();
    t_inhibit();
    t_decimal();
    t_logic();
    t_judge();
    t_index();
    t_rotate();
    end_of_test();
  end
endmodule
`default_nettype wire
